// file: smrc_pkg.sv
// package for the supply monitor and reference control block
// assumes a 32-bit axi4-lite register bus and one 50 mhz clock
package smrc_pkg;

   // ********************************************************
   // register map (byte addresses)
   // ********************************************************
   localparam logic [7:0] ADDR_STATUS   = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS    = 8'h08;
   localparam logic [7:0] ADDR_BROWNOUT = 8'h10;
   localparam logic [7:0] ADDR_REGUL    = 8'h18;
   localparam logic [7:0] ADDR_REFER    = 8'h1c;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int LEVEL_LSB   = 16;
   localparam int PSEL_LSB    = 12;
   localparam int ACTCHO_BIT  = 8;
   localparam int SLKEEP_BIT  = 6;
   localparam int SLCHO_BIT   = 5;
   localparam int ACTION_LSB  = 3;
   localparam int MARGIN_BIT  = 2;
   localparam int ENABLE_BIT  = 1;
   localparam int REG_RUN_BIT = 6;
   localparam int REG_ONE_BIT = 1;
   localparam int REF_SEL_LSB = 16;
   localparam int REF_DEM_BIT = 7;
   localparam int REF_RUN_BIT = 6;
   localparam int REF_OE_BIT  = 2;
   localparam int ST_READY    = 0;
   localparam int ST_DETECT   = 1;
   localparam int ST_SYNC     = 2;

   // ********************************************************
   // reset values and timing
   // ********************************************************
   localparam logic [31:0] REGUL_RESET = 32'h0000_0002;
   localparam logic [31:0] REFER_RESET = 32'h0000_0000;
   localparam int          CLK_HZ      = 50_000_000;
   localparam int          LPO_HZ      = 1024;
   // cycles of aclk per low-power oscillator period, rounded down
   localparam int          LPO_CYCLES  = CLK_HZ / LPO_HZ;
   localparam int          SYNC_CYCLES = 3;

   localparam logic [1:0] ACT_NONE  = 2'h0;
   localparam logic [1:0] ACT_RESET = 2'h1;
   localparam logic [1:0] ACT_INT   = 2'h2;
   localparam logic [3:0] SEL_1V024 = 4'h0;
   localparam logic [3:0] SEL_2V048 = 4'h2;
   localparam logic [3:0] SEL_4V096 = 4'h3;

   // detector configuration travelling together
   typedef struct packed {
      logic [5:0] level;
      logic [3:0] psel;
      logic       active_sampling_choice;
      logic       keep_on_in_sleep;
      logic       sleep_sampling_choice;
      logic [1:0] action;
      logic       threshold_margin_on;
   } smrc_det_cfg_t;

   // start-up values from the nonvolatile user row
   typedef struct packed {
      smrc_det_cfg_t cfg;
      logic          enable;
   } smrc_nvm_t;

endpackage : smrc_pkg

// file: smrc_sampler.sv
// sampling engine for the dropout detector
// assumes the analog compare arrives synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module smrc_sampler
   import smrc_pkg::*;
#(
   parameter int LPO_DIV = LPO_CYCLES
)
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // control
   input  wire logic       run,
   input  wire logic       sampling,
   input  wire logic [3:0] psel,
   input  wire logic       below,
   // result
   output logic            detected
);
   logic [31:0] lpo_cnt;
   logic [15:0] pre_cnt;
   logic        lpo_tick;
   logic        sample_tick;
   logic [15:0] pre_last;

   assign lpo_tick    = (lpo_cnt == 32'(LPO_DIV - 1));
   // code n divides the slow clock by 2**(n+1)
   assign pre_last    = 16'((32'd2 << psel) - 32'd1);
   assign sample_tick = lpo_tick && (pre_cnt == pre_last);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         lpo_cnt <= '0;
         pre_cnt <= '0;
      end
      else if (lpo_tick)
      begin
         lpo_cnt <= '0;
         pre_cnt <= (pre_cnt == pre_last) ? 16'h0 : pre_cnt + 16'h1;
      end
      else
         lpo_cnt <= lpo_cnt + 32'h1;
   end

   // sampling holds its result between samples
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run)
         detected <= 1'b0;
      else if (!sampling || sample_tick)
         detected <= below;
   end
endmodule : smrc_sampler
`default_nettype wire

// file: smrc_top.sv
// register bank of the supply monitor and reference control
// assumes an axi4-lite master on aclk, nvm values stable at reset release
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module smrc_top
   import smrc_pkg::*;
#(
   parameter int LPO_DIV = LPO_CYCLES
)
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // start-up values and system state
   input  wire smrc_nvm_t   nvm_row,
   input  wire logic        access_guard_lock,
   input  wire logic        standby,
   input  wire logic        supply_below,
   input  wire logic        reference_request,
   // detector controls
   output smrc_det_cfg_t    det_cfg,
   output logic             det_enabled,
   output logic             det_running,
   output logic             det_reset_req,
   output logic             det_irq_req,
   // regulator and reference controls
   output logic             regulator_normal_in_sleep,
   output logic [3:0]       internal_reference,
   output logic             reference_on,
   output logic             reference_to_converter_route
);
   // ********************************************************
   // state
   // ********************************************************
   smrc_det_cfg_t cfg;
   logic          enable;
   logic          enable_live;
   logic [1:0]    sync_cnt;
   logic          dropout_sync_done;
   logic          dropout_detected;
   logic          detected_q;
   logic          flag_detect;
   logic          flag_sync;
   logic          flag_ready;
   logic          sync_q;
   logic          regul_run;
   logic          regul_one;
   logic [3:0]    ref_sel;
   logic          ref_dem;
   logic          ref_run;
   logic          ref_oe;
   logic          boot;

   // ********************************************************
   // axi4-lite write path
   // ********************************************************
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   wire         do_write = aw_held && w_held && !s_axi_bvalid;
   wire         wr_bo    = do_write && aw_addr == ADDR_BROWNOUT;
   wire         wr_rg    = do_write && aw_addr == ADDR_REGUL;
   wire         wr_rf    = do_write && aw_addr == ADDR_REFER;
   wire         wr_fl    = do_write && aw_addr == ADDR_FLAGS;
   wire         wr_ok    = wr_bo || wr_rg || wr_rf || wr_fl ||
                           (do_write && aw_addr == ADDR_STATUS);
   wire         locked   = access_guard_lock;
   wire         wr_prot  = wr_bo && !locked && !enable;
   wire         wr_en    = wr_bo && !locked && w_strb[0];
   wire         clr_det  = wr_fl && w_strb[0] && w_data[ST_DETECT];
   wire         clr_syn  = wr_fl && w_strb[0] && w_data[ST_SYNC];
   wire         clr_rdy  = wr_fl && w_strb[0] && w_data[ST_READY];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         // no new request is taken while the answer waits for bready
         s_axi_awready <= !aw_held && !s_axi_bvalid &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held && !s_axi_bvalid &&
                          !(s_axi_wvalid && s_axi_wready);
      end
   end

   // ********************************************************
   // configuration registers
   // ********************************************************
   // nvm row is taken by a clocked load in the first cycle after release
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         boot   <= 1'b1;
         cfg    <= '0;
         enable <= 1'b0;
      end
      else if (boot)
      begin
         boot   <= 1'b0;
         cfg    <= nvm_row.cfg;
         enable <= nvm_row.enable;
      end
      else
      begin
         if (wr_prot && w_strb[2])
            cfg.level <= w_data[LEVEL_LSB +: 6];
         if (wr_prot && w_strb[1])
         begin
            cfg.psel <= w_data[PSEL_LSB +: 4];
            cfg.active_sampling_choice <= w_data[ACTCHO_BIT];
         end
         if (wr_prot && w_strb[0])
         begin
            cfg.keep_on_in_sleep      <= w_data[SLKEEP_BIT];
            cfg.sleep_sampling_choice <= w_data[SLCHO_BIT];
            cfg.action                <= w_data[ACTION_LSB +: 2];
            cfg.threshold_margin_on   <= w_data[MARGIN_BIT];
         end
         if (wr_en)
            enable <= w_data[ENABLE_BIT];
      end
   end

   // enable reaches the detector a few cycles after the write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_cnt    <= 2'h0;
         enable_live <= 1'b0;
      end
      else if (wr_en || boot)
         sync_cnt <= 2'(SYNC_CYCLES);
      else if (sync_cnt != 2'h0)
      begin
         sync_cnt <= sync_cnt - 2'h1;
         if (sync_cnt == 2'h1)
            enable_live <= enable;
      end
   end
   assign dropout_sync_done = (sync_cnt == 2'h0);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         regul_run <= 1'b0;
         regul_one <= REGUL_RESET[REG_ONE_BIT];
         ref_sel   <= REFER_RESET[REF_SEL_LSB +: 4];
         ref_dem   <= 1'b0;
         ref_run   <= 1'b0;
         ref_oe    <= 1'b0;
      end
      else
      begin
         if (wr_rg && !locked && w_strb[0])
         begin
            regul_run <= w_data[REG_RUN_BIT];
            regul_one <= w_data[REG_ONE_BIT];
         end
         if (wr_rf && !locked && w_strb[2])
            ref_sel <= w_data[REF_SEL_LSB +: 4];
         if (wr_rf && !locked && w_strb[0])
         begin
            ref_dem <= w_data[REF_DEM_BIT];
            ref_run <= w_data[REF_RUN_BIT];
            ref_oe  <= w_data[REF_OE_BIT];
         end
      end
   end

   // ********************************************************
   // detector operation
   // ********************************************************
   wire det_run  = enable_live && (!standby || cfg.keep_on_in_sleep);
   wire det_samp = standby ? cfg.sleep_sampling_choice
                           : cfg.active_sampling_choice;

   smrc_sampler #(.LPO_DIV(LPO_DIV)) u_sampler (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (det_run),
      .sampling (det_samp),
      .psel     (cfg.psel),
      .below    (supply_below),
      .detected (dropout_detected)
   );

   // flags: a set in the same cycle as a clear wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         detected_q  <= 1'b0;
         sync_q      <= 1'b1;
         flag_detect <= 1'b0;
         flag_sync   <= 1'b0;
         flag_ready  <= 1'b0;
      end
      else
      begin
         detected_q  <= dropout_detected;
         sync_q      <= dropout_sync_done;
         flag_detect <= (dropout_detected && !detected_q) ||
                        (flag_detect && !clr_det);
         flag_sync   <= (dropout_sync_done && !sync_q) ||
                        (flag_sync && !clr_syn);
         flag_ready  <= (det_run && !det_running) ||
                        (flag_ready && !clr_rdy);
      end
   end

   // ********************************************************
   // outputs and read path
   // ********************************************************
   wire ref_want = ref_dem ? reference_request : 1'b1;
   wire ref_live = standby ? (ref_run && ref_want) : ref_want;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         det_cfg                      <= '0;
         det_enabled                  <= 1'b0;
         det_running                  <= 1'b0;
         det_reset_req                <= 1'b0;
         det_irq_req                  <= 1'b0;
         regulator_normal_in_sleep    <= 1'b0;
         internal_reference           <= SEL_1V024;
         reference_on                 <= 1'b0;
         reference_to_converter_route <= 1'b0;
      end
      else
      begin
         det_cfg       <= cfg;
         det_enabled   <= enable_live;
         det_running   <= det_run;
         det_reset_req <= dropout_detected && cfg.action == ACT_RESET;
         det_irq_req   <= flag_detect && cfg.action == ACT_INT;
         regulator_normal_in_sleep    <= regul_run;
         internal_reference           <= ref_sel;
         reference_on                 <= ref_live;
         reference_to_converter_route <= ref_oe;
      end
   end

   logic [31:0] rd_word;
   logic        rd_ok;
   wire  [7:0]  ra = {s_axi_araddr[7:2], 2'b00};
   always_comb
   begin
      rd_ok   = 1'b1;
      rd_word = 32'h0;
      case (ra)
         ADDR_FLAGS:    rd_word = {29'h0, flag_sync, flag_detect, flag_ready};
         ADDR_STATUS:   rd_word = {29'h0, dropout_sync_done,
                                   dropout_detected, det_running};
         ADDR_BROWNOUT: rd_word = {10'h0, cfg.level, cfg.psel, 3'h0,
                                   cfg.active_sampling_choice, 1'b0,
                                   cfg.keep_on_in_sleep,
                                   cfg.sleep_sampling_choice, cfg.action,
                                   cfg.threshold_margin_on, enable, 1'b0};
         ADDR_REGUL:    rd_word = {25'h0, regul_run, 4'h0, regul_one, 1'b0};
         ADDR_REFER:    rd_word = {12'h0, ref_sel, 8'h0, ref_dem, ref_run,
                                   3'h0, ref_oe, 2'h0};
         default:       rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : smrc_top
`default_nettype wire

// file: smrc_top_chk.sv
// checker for the supply monitor register bank outputs
// assumes it is bound onto every smrc_top instance
`timescale 1ns/10ps
`default_nettype none
module smrc_top_chk
   import smrc_pkg::*;
(
   // clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // bus handshakes
   input  wire logic          s_axi_awvalid,
   input  wire logic          s_axi_awready,
   input  wire logic          s_axi_bvalid,
   input  wire logic          s_axi_arvalid,
   input  wire logic          s_axi_arready,
   input  wire logic          s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // detector state
   input  wire logic          standby,
   input  wire smrc_det_cfg_t det_cfg,
   input  wire logic          det_enabled,
   input  wire logic          det_running,
   input  wire logic          det_reset_req,
   input  wire logic          det_irq_req
);
   // ********************************************************
   // properties
   // ********************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_aw_taken;
      s_axi_awvalid && s_axi_awready;
   endsequence
   // three cycles allow for the registered copy of the config
   sequence s_asleep;
      (standby && !det_cfg.keep_on_in_sleep) [*3];
   endsequence

   a_read_answer: assert property (s_ar_taken |-> ##[1:2] s_axi_rvalid)
      else $error("read answer missing");
   a_write_answer: assert property (s_aw_taken |-> ##[1:4] s_axi_bvalid)
      else $error("write answer missing");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answering");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write accepted while answering");
   a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer held after handshake");
   a_sleep_halt: assert property (s_asleep |-> !det_running)
      else $error("detector runs in standby");
   a_off_idle: assert property ((!det_enabled) [*3] |-> !det_running)
      else $error("detector runs while disabled");
   a_irq_action: assert property (det_irq_req |->
      (det_cfg.action == ACT_INT || $past(det_cfg.action) == ACT_INT))
      else $error("interrupt request without interrupt action");
   a_reset_action: assert property (det_reset_req |->
      (det_cfg.action == ACT_RESET || $past(det_cfg.action) == ACT_RESET))
      else $error("reset request without reset action");
endmodule : smrc_top_chk

bind smrc_top smrc_top_chk chk_u (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .standby, .det_cfg, .det_enabled,
   .det_running, .det_reset_req, .det_irq_req);
`default_nettype wire

// file: smrc_top_tb_top.sv
// self-checking bench for smrc_top driven over axi4-lite
// assumes the checker binds itself; sample period shortened by LPO_DIV
`timescale 1ns/10ps
`default_nettype none
module smrc_top_tb_top
   import smrc_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, standby = 1'b1, supply_below = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, access_guard_lock = 1'b0;
   logic reference_request = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, det_enabled, det_running, det_reset_req;
   logic det_irq_req, regulator_normal_in_sleep, reference_on;
   logic reference_to_converter_route;
   logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]    s_axi_wstrb = 4'hf, internal_reference;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [3:0]    sels [3] = '{SEL_1V024, SEL_2V048, SEL_4V096};
   smrc_nvm_t     nvm_row = {6'h2a, 4'h5, 3'b000, 2'h2, 1'b1, 1'b0};
   smrc_det_cfg_t det_cfg;
   int            n_fail = 0, tests_run = 0;

   smrc_top #(.LPO_DIV(4)) dut_u (.aclk, .aresetn, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .nvm_row, .access_guard_lock,
      .standby, .supply_below, .reference_request, .det_cfg, .det_enabled,
      .det_running, .det_reset_req, .det_irq_req, .regulator_normal_in_sleep,
      .internal_reference, .reference_on, .reference_to_converter_route);

   always #10 aclk = ~aclk;

   // ********************************************************
   // bus tasks and checks
   // ********************************************************
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic hang;
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
   endtask : hang

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // every write must answer okay, even when dropped by the lock
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 40 && !s_axi_bvalid; n++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      if (n == 40)
         hang();
      chk(s_axi_bresp, 2'h0);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 40 && !s_axi_rvalid; n++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      if (n == 40)
         hang();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d, exp);
   endtask : rd_chk

   task automatic poll(input logic [7:0] a, input int b);
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      d = 32'h0;
      for (n = 0; n < 30 && d[b] !== 1'b1; n++)
         rd(a, d, r);
      if (d[b] !== 1'b1)
         hang();
   endtask : poll

   function automatic logic [31:0] bo(input smrc_det_cfg_t c, input logic en);
      bo = {10'h0, c.level, c.psel, 3'h0, c.active_sampling_choice, 1'b0,
            c.keep_on_in_sleep, c.sleep_sampling_choice, c.action,
            c.threshold_margin_on, en, 1'b0};
   endfunction : bo

   // ********************************************************
   // main sequence
   // ********************************************************
   initial
   begin
      logic [31:0]   d;
      logic [1:0]    r;
      int            i;
      smrc_det_cfg_t c1;
      smrc_det_cfg_t c2;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd_chk(ADDR_BROWNOUT, bo(nvm_row.cfg, 1'b0));
      rd_chk(ADDR_REGUL, REGUL_RESET);
      rd_chk(ADDR_REFER, REFER_RESET);
      chk(det_cfg, nvm_row.cfg);
      standby <= 1'b0;
      c1 = {6'h3f, 4'hf, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0};
      for (i = 0; i < 4; i++)
      begin
         c1.action = i[1:0];
         wr(ADDR_BROWNOUT, bo(c1, 1'b0));
         rd_chk(ADDR_BROWNOUT, bo(c1, 1'b0));
      end
      chk(det_cfg, c1);
      // short prescale so a sample falls every eight cycles
      c2 = {6'h15, 4'h0, 1'b1, 1'b1, 1'b0, ACT_INT, 1'b1};
      wr(ADDR_BROWNOUT, bo(c2, 1'b0));
      // let this write's sync finish, or its flag set beats the clear below
      poll(ADDR_STATUS, ST_SYNC);
      wr(ADDR_FLAGS, 32'h7);
      wr(ADDR_BROWNOUT, bo(c2, 1'b1));
      chk(det_enabled, 1'b0);
      poll(ADDR_FLAGS, ST_SYNC);
      chk(det_enabled, 1'b1);
      wr(ADDR_BROWNOUT, bo(c1, 1'b1));
      rd_chk(ADDR_BROWNOUT, bo(c2, 1'b1));
      supply_below <= 1'b1;
      poll(ADDR_STATUS, ST_DETECT);
      chk(det_irq_req, 1'b1);
      supply_below <= 1'b0;
      wr(ADDR_FLAGS, 32'h0);
      rd(ADDR_FLAGS, d, r);
      chk(d[ST_DETECT], 1'b1);
      repeat (16) @(posedge aclk);
      wr(ADDR_FLAGS, 32'h1 << ST_DETECT);
      rd(ADDR_FLAGS, d, r);
      chk(d[ST_DETECT], 1'b0);
      rd(ADDR_STATUS, d, r);
      chk(d[ST_DETECT], 1'b0);
      standby <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(det_running, 1'b1);
      standby <= 1'b0;
      wr(ADDR_BROWNOUT, bo(c2, 1'b0));
      rd_chk(ADDR_BROWNOUT, bo(c2, 1'b0));
      for (i = 0; i < 3; i++)
      begin
         wr(ADDR_REFER, {12'h0, sels[i], 16'h0084});
         rd_chk(ADDR_REFER, {12'h0, sels[i], 16'h0084});
         chk(internal_reference, sels[i]);
      end
      chk(reference_on, 1'b0);
      chk(reference_to_converter_route, 1'b1);
      reference_request <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(reference_on, 1'b1);
      standby <= 1'b1;
      wr(ADDR_REFER, 32'h0);
      chk(reference_on, 1'b0);
      chk(reference_to_converter_route, 1'b0);
      wr(ADDR_REFER, 32'h40);
      chk(reference_on, 1'b1);
      standby <= 1'b0;
      wr(ADDR_REGUL, 32'h42);
      rd_chk(ADDR_REGUL, 32'h42);
      chk(regulator_normal_in_sleep, 1'b1);
      access_guard_lock <= 1'b1;
      wr(ADDR_REGUL, REGUL_RESET);
      wr(ADDR_REFER, 32'h84);
      wr(ADDR_BROWNOUT, bo(c1, 1'b0));
      rd_chk(ADDR_REGUL, 32'h42);
      rd_chk(ADDR_REFER, 32'h40);
      rd_chk(ADDR_BROWNOUT, bo(c2, 1'b0));
      access_guard_lock <= 1'b0;
      // continuous detector asking for a reset, then halted by standby
      c1 = {6'h15, 4'h0, 1'b0, 1'b0, 1'b0, ACT_RESET, 1'b0};
      wr(ADDR_BROWNOUT, bo(c1, 1'b1));
      poll(ADDR_STATUS, ST_SYNC);
      supply_below <= 1'b1;
      poll(ADDR_STATUS, ST_DETECT);
      chk(det_reset_req, 1'b1);
      chk(det_irq_req, 1'b0);
      standby <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(det_running, 1'b0);
      supply_below <= 1'b0;
      standby <= 1'b0;
      rd(8'h40, d, r);
      chk(r, 2'h2);
      // second reset: the enable now comes from the start-up row
      aresetn <= 1'b0;
      nvm_row.enable <= 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd_chk(ADDR_BROWNOUT, bo(nvm_row.cfg, 1'b1));
      poll(ADDR_STATUS, ST_SYNC);
      chk(det_enabled, 1'b1);
      final_report();
   end
endmodule : smrc_top_tb_top
`default_nettype wire
